// [logic/timer_unit.sv]
`include "timer_map.svh"

// How it works
// - Timer 1 in mode 3 stops and holds its count, like a cleared run bit.
// - Timer 0 mode 3 splits into two 8-bit counters; low byte keeps timer 0 controls.
// - In that split, the high byte counts machine cycles, runs on t1_run, sets t1 flag.
// - Timer 1 then runs outside mode 3 unless its gate holds it, halts inside, still feeding baud ticks.
// - Overflow flags at status bits 7 and 5 set on overflow, cleared on vectoring.
// - Run bits at status bits 6 and 4 switch timers 1 and 0 on and off.
// - Edge flags at bits 3 and 1 set on a detected edge, cleared when processed.
// - Type bits at bits 2 and 0 select falling edge when set, low level when clear.
// - Timer 2 is a 16-bit up counter; bit 1 picks machine cycles or pin falls.
// - Timer 2 overflow flag sets on overflow, cleared by software, never in baud mode.
// - Timer 2 external flag sets on trigger capture or reload; software clears it.
// - Receive select set takes timer 2 overflows as receive clock, else timer 1.
// - Transmit select set takes timer 2 overflows as transmit clock, else timer 1.
// - External enable lets trigger falls capture or reload, except in baud mode.
// - Timer 2 run bit starts the timer at 1 and stops it at 0.
// - Capture/reload select picks capture or reload; baud mode forces reload.
// - Capture mode: overflow sets flag; trigger fall copies count and sets external flag.
// - Reload mode: rollover loads capture value; enabled trigger fall also reloads.
// - Either clock-select bit puts timer 2 into baud generator mode.
// - As a timer a counter steps once per machine cycle of twelve oscillator periods; timer 2 in baud mode once per state time.
// - As a counter the pin is sampled once a cycle; high then low counts one.

module timer_unit
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire reg_bus_t bus,
  input wire ext_pins_t pins,
  input wire irq_ack_t ack,
  output logic [7:0] read_data,
  output logic t0_irq,
  output logic t1_irq,
  output logic ext_irq0_req,
  output logic ext_irq1_req,
  output logic t2_irq,
  output logic rx_baud_tick,
  output logic tx_baud_tick
);

  // Step for modes 0, 1 and 2: returns overflow, high byte, low byte
  function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    logic [5:0] lo5;
    logic [8:0] hi9;
    logic [8:0] lo9;
    logic [16:0] full;
    count_step = {1'b0, hi, lo};
    lo5 = {1'b0, lo[4:0]} + 6'h01;
    hi9 = {1'b0, hi} + 9'h001;
    lo9 = {1'b0, lo} + 9'h001;
    full = {1'b0, hi, lo} + 17'h00001;
    unique case (mode)
      2'h0: begin
        // 13-bit: upper three low-byte bits are left alone
        if (lo5[5]) begin
          count_step = {hi9, lo[7:5], lo5[4:0]};
        end else begin
          count_step = {1'b0, hi, lo[7:5], lo5[4:0]};
        end
      end
      2'h1: begin
        count_step = full;
      end
      2'h2: begin
        if (lo9[8]) begin
          count_step = {1'b1, hi, hi};
        end else begin
          count_step = {1'b0, hi, lo9[7:0]};
        end
      end
      2'h3: begin
        count_step = {1'b0, hi, lo};
      end
    endcase
  endfunction

  logic machine_tick;
  logic state_tick;
  logic sample_tick;
  ext_pins_t pin_level;
  ext_pins_t pin_fall;

  phase_gen u_phase (
    .clock(clock),
    .rst_n(rst_n),
    .machine_tick(machine_tick),
    .state_tick(state_tick),
    .sample_tick(sample_tick)
  );

  // All pins, trigger included, pass the same sampler
  pin_sampler #(.WIDTH($bits(ext_pins_t))) u_sampler (
    .clock(clock),
    .rst_n(rst_n),
    .sample_tick(sample_tick),
    .pins(pins),
    .level(pin_level),
    .fall(pin_fall)
  );

  unit_state_t q, d;

  logic [1:0] t0_mode;
  logic [1:0] t1_mode;
  logic t0_split;
  logic t0_ok;
  logic t1_ok;
  logic t0_inc;
  logic t1_inc;
  logic th0_inc;
  logic [16:0] t0_next;
  logic [16:0] t1_next;
  logic [8:0] tl0_next;
  logic [8:0] th0_next;
  logic t1_overflow;
  logic baud_mode;
  logic t2_inc;
  logic [16:0] t2_next;
  logic t2_overflow;
  logic t2_trigger;
  logic [7:0] cs;
  logic [7:0] t2c;

  always_comb begin
    d = q;
    cs = q.timer_ctrl_status;
    t2c = q.timer2_ctrl;
    t0_mode = q.timer_mode_reg[`MODE_SEL_HI:`MODE_SEL_LO];
    t1_mode = q.timer_mode_reg[`MODE_SEL_HI + 4:`MODE_SEL_LO + 4];
    t0_split = (t0_mode == `MODE_SPLIT);

    // Software side first; hardware sets below win over a clear in the same cycle
    if (bus.wr) begin
      unique case (bus.addr)
        `OFS_TIMER_MODE: d.timer_mode_reg = bus.wdata;
        `OFS_TIMER_CTRL_STATUS: cs = bus.wdata;
        `OFS_TIMER2_CTRL: t2c = bus.wdata;
        default: ;
      endcase
    end
    // Vectoring clears the overflow flags and the edge flags
    if (ack.t0) begin
      cs[`CS_T0_OVF] = 1'b0;
    end
    if (ack.t1) begin
      cs[`CS_T1_OVF] = 1'b0;
    end
    if (ack.x0) begin
      cs[`CS_IRQ0_EDGE] = 1'b0;
    end
    if (ack.x1) begin
      cs[`CS_IRQ1_EDGE] = 1'b0;
    end

    // Timer 0: gate lets the interrupt pin hold the count off
    t0_ok = q.timer_ctrl_status[`CS_T0_RUN] & (~q.timer_mode_reg[`MODE_GATE] | pin_level.irq0);
    t0_inc = t0_ok & (q.timer_mode_reg[`MODE_CT] ? pin_fall.t0_cnt : machine_tick);
    t0_next = count_step(t0_mode, q.t0_low_byte, q.t0_high_byte);
    tl0_next = {1'b0, q.t0_low_byte} + 9'h001;
    th0_next = {1'b0, q.t0_high_byte} + 9'h001;
    // In split mode the high byte borrows timer 1's run bit and flag
    th0_inc = t0_split & q.timer_ctrl_status[`CS_T1_RUN] & machine_tick;

    if (t0_split) begin
      if (t0_inc) begin
        d.t0_low_byte = tl0_next[7:0];
        if (tl0_next[8]) begin
          cs[`CS_T0_OVF] = 1'b1;
        end
      end
      if (th0_inc) begin
        d.t0_high_byte = th0_next[7:0];
        if (th0_next[8]) begin
          cs[`CS_T1_OVF] = 1'b1;
        end
      end
    end else if (t0_inc) begin
      d.t0_low_byte = t0_next[7:0];
      d.t0_high_byte = t0_next[15:8];
      if (t0_next[16]) begin
        cs[`CS_T0_OVF] = 1'b1;
      end
    end

    // Timer 1: with timer 0 split, its run bit is taken, so only mode 3 or its gate stops it
    t1_ok = (t0_split | q.timer_ctrl_status[`CS_T1_RUN])
      & (~q.timer_mode_reg[`MODE_GATE + 4] | pin_level.irq1)
      & (t1_mode != `MODE_SPLIT);
    t1_inc = t1_ok & (q.timer_mode_reg[`MODE_CT + 4] ? pin_fall.t1_cnt : machine_tick);
    t1_next = count_step(t1_mode, q.t1_low_byte, q.t1_high_byte);
    t1_overflow = t1_inc & t1_next[16];
    if (t1_inc) begin
      d.t1_low_byte = t1_next[7:0];
      d.t1_high_byte = t1_next[15:8];
    end
    // Flag belongs to the split high byte then; overflow still clocks the serial port
    if (t1_overflow && !t0_split) begin
      cs[`CS_T1_OVF] = 1'b1;
    end

    // External interrupts: edge mode latches falls, level mode follows the pin
    if (q.timer_ctrl_status[`CS_IRQ0_TYPE]) begin
      if (pin_fall.irq0) begin
        cs[`CS_IRQ0_EDGE] = 1'b1;
      end
    end else begin
      cs[`CS_IRQ0_EDGE] = ~pin_level.irq0;
    end
    if (q.timer_ctrl_status[`CS_IRQ1_TYPE]) begin
      if (pin_fall.irq1) begin
        cs[`CS_IRQ1_EDGE] = 1'b1;
      end
    end else begin
      cs[`CS_IRQ1_EDGE] = ~pin_level.irq1;
    end

    // Timer 2: baud mode steps every state time instead of every machine cycle
    baud_mode = q.timer2_ctrl[`T2C_RX_SEL] | q.timer2_ctrl[`T2C_TX_SEL];
    if (q.timer2_ctrl[`T2C_CT]) begin
      t2_inc = q.timer2_ctrl[`T2C_RUN] & pin_fall.t2_cnt;
    end else begin
      t2_inc = q.timer2_ctrl[`T2C_RUN] & (baud_mode ? state_tick : machine_tick);
    end
    t2_next = {1'b0, q.t2_high_byte, q.t2_low_byte} + 17'h00001;
    t2_overflow = t2_inc & t2_next[16];
    t2_trigger = q.timer2_ctrl[`T2C_EXT_EN] & pin_fall.t2_trig;

    if (t2_inc) begin
      d.t2_low_byte = t2_next[7:0];
      d.t2_high_byte = t2_next[15:8];
    end
    if (t2_overflow) begin
      if (baud_mode || !q.timer2_ctrl[`T2C_CAP_RL]) begin
        d.t2_low_byte = q.t2_capture_low;
        d.t2_high_byte = q.t2_capture_high;
      end
      if (!baud_mode) begin
        t2c[`T2C_OVF] = 1'b1;
      end
    end
    if (t2_trigger) begin
      // Baud mode keeps the trigger as a spare interrupt with no reload
      t2c[`T2C_EXT] = 1'b1;
      if (!baud_mode) begin
        if (q.timer2_ctrl[`T2C_CAP_RL]) begin
          d.t2_capture_low = q.t2_low_byte;
          d.t2_capture_high = q.t2_high_byte;
        end else begin
          d.t2_low_byte = q.t2_capture_low;
          d.t2_high_byte = q.t2_capture_high;
        end
      end
    end

    // Software writes to counts land last, so a write is never lost to a step
    if (bus.wr) begin
      unique case (bus.addr)
        `OFS_T0_LOW: d.t0_low_byte = bus.wdata;
        `OFS_T0_HIGH: d.t0_high_byte = bus.wdata;
        `OFS_T1_LOW: d.t1_low_byte = bus.wdata;
        `OFS_T1_HIGH: d.t1_high_byte = bus.wdata;
        `OFS_T2_LOW: d.t2_low_byte = bus.wdata;
        `OFS_T2_HIGH: d.t2_high_byte = bus.wdata;
        `OFS_T2_CAPTURE_LOW: d.t2_capture_low = bus.wdata;
        `OFS_T2_CAPTURE_HIGH: d.t2_capture_high = bus.wdata;
        default: ;
      endcase
    end
    d.timer_ctrl_status = cs;
    d.timer2_ctrl = t2c;

    // Serial bit clocks chosen per direction
    d.rx_tick = q.timer2_ctrl[`T2C_RX_SEL] ? (t2_overflow & baud_mode) : t1_overflow;
    d.tx_tick = q.timer2_ctrl[`T2C_TX_SEL] ? (t2_overflow & baud_mode) : t1_overflow;
    d.t2_irq = t2c[`T2C_OVF] | t2c[`T2C_EXT];

    // Read data stands one cycle only; unmapped offsets read zero
    d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `OFS_TIMER_MODE: d.rdata = q.timer_mode_reg;
        `OFS_TIMER_CTRL_STATUS: d.rdata = q.timer_ctrl_status;
        `OFS_T0_LOW: d.rdata = q.t0_low_byte;
        `OFS_T0_HIGH: d.rdata = q.t0_high_byte;
        `OFS_T1_LOW: d.rdata = q.t1_low_byte;
        `OFS_T1_HIGH: d.rdata = q.t1_high_byte;
        `OFS_TIMER2_CTRL: d.rdata = q.timer2_ctrl;
        `OFS_T2_LOW: d.rdata = q.t2_low_byte;
        `OFS_T2_HIGH: d.rdata = q.t2_high_byte;
        `OFS_T2_CAPTURE_LOW: d.rdata = q.t2_capture_low;
        `OFS_T2_CAPTURE_HIGH: d.rdata = q.t2_capture_high;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign read_data = q.rdata;
  assign t0_irq = q.timer_ctrl_status[`CS_T0_OVF];
  assign t1_irq = q.timer_ctrl_status[`CS_T1_OVF];
  assign ext_irq0_req = q.timer_ctrl_status[`CS_IRQ0_EDGE];
  assign ext_irq1_req = q.timer_ctrl_status[`CS_IRQ1_EDGE];
  assign t2_irq = q.t2_irq;
  assign rx_baud_tick = q.rx_tick;
  assign tx_baud_tick = q.tx_tick;
endmodule

// [logic/timer_map.svh]
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Register offsets on the plain register port
`define OFS_TIMER_MODE 4'h0
`define OFS_TIMER_CTRL_STATUS 4'h1
`define OFS_T0_LOW 4'h2
`define OFS_T0_HIGH 4'h3
`define OFS_T1_LOW 4'h4
`define OFS_T1_HIGH 4'h5
`define OFS_TIMER2_CTRL 4'h6
`define OFS_T2_LOW 4'h7
`define OFS_T2_HIGH 4'h8
`define OFS_T2_CAPTURE_LOW 4'h9
`define OFS_T2_CAPTURE_HIGH 4'hA

// Reset values
`define RESET_BYTE 8'h00

// Timer control and status bit positions
`define CS_T1_OVF 7
`define CS_T1_RUN 6
`define CS_T0_OVF 5
`define CS_T0_RUN 4
`define CS_IRQ1_EDGE 3
`define CS_IRQ1_TYPE 2
`define CS_IRQ0_EDGE 1
`define CS_IRQ0_TYPE 0

// Timer 2 control bit positions
`define T2C_OVF 7
`define T2C_EXT 6
`define T2C_RX_SEL 5
`define T2C_TX_SEL 4
`define T2C_EXT_EN 3
`define T2C_RUN 2
`define T2C_CT 1
`define T2C_CAP_RL 0

// Field positions inside one timer's nibble of the mode register
`define MODE_GATE 3
`define MODE_CT 2
`define MODE_SEL_HI 1
`define MODE_SEL_LO 0
`define MODE_SPLIT 2'h3

// Timing in oscillator periods (the clock is the oscillator)
`define OSC_PER_MACHINE 12
`define OSC_PER_STATE 2
`define SAMPLE_PHASE 9

`endif

// [logic/timer_pkg.sv]
package timer_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;

  typedef struct packed {
    logic irq1;
    logic irq0;
    logic t2_trig;
    logic t2_cnt;
    logic t1_cnt;
    logic t0_cnt;
  } ext_pins_t;

  typedef struct packed {
    logic x1;
    logic x0;
    logic t1;
    logic t0;
  } irq_ack_t;

  typedef struct packed {
    logic [7:0] timer_mode_reg;
    logic [7:0] timer_ctrl_status;
    logic [7:0] t0_low_byte;
    logic [7:0] t0_high_byte;
    logic [7:0] t1_low_byte;
    logic [7:0] t1_high_byte;
    logic [7:0] timer2_ctrl;
    logic [7:0] t2_low_byte;
    logic [7:0] t2_high_byte;
    logic [7:0] t2_capture_low;
    logic [7:0] t2_capture_high;
    logic [7:0] rdata;
    logic rx_tick;
    logic tx_tick;
    logic t2_irq;
  } unit_state_t;

  typedef struct packed {
    logic [3:0] phase;
  } phase_state_t;

endpackage

// [logic/phase_gen.sv]
`include "timer_map.svh"

module phase_gen
  import timer_pkg::*;
#(
  parameter int OSC_PER_MC = `OSC_PER_MACHINE,
  parameter int SAMPLE_AT = `SAMPLE_PHASE
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic machine_tick,
  output logic state_tick,
  output logic sample_tick
);
  localparam logic [3:0] LAST = 4'(OSC_PER_MC - 1);
  localparam logic [3:0] SAMPLE = 4'(SAMPLE_AT);

  phase_state_t q, d;

  always_comb begin
    d = q;
    d.phase = (q.phase == LAST) ? 4'h0 : q.phase + 4'h1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // One pulse per machine cycle, one per state time, one at the pin sample point
  assign machine_tick = (q.phase == LAST);
  assign state_tick = q.phase[0];
  assign sample_tick = (q.phase == SAMPLE);
endmodule

// [logic/pin_sampler.sv]
module pin_sampler
  import timer_pkg::*;
#(
  parameter int WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] fall;
  } sample_state_t;

  sample_state_t q, d;

  // A high sample followed by a low sample gives one fall pulse of one clock
  always_comb begin
    d = q;
    d.fall = '0;
    if (sample_tick) begin
      d.fall = q.level & ~pins;
      d.level = pins;
    end
  end

  // Pins idle high so no spurious fall is seen straight after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{level: '1, fall: '0};
    end else begin
      q <= d;
    end
  end

  assign level = q.level;
  assign fall = q.fall;
endmodule

// [verification/timer_unit_chk.sv]
module timer_unit_chk
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire reg_bus_t bus,
  input wire ext_pins_t pins,
  input wire irq_ack_t ack,
  input wire logic [7:0] read_data,
  input wire logic t0_irq,
  input wire logic t1_irq,
  input wire logic ext_irq0_req,
  input wire logic ext_irq1_req,
  input wire logic t2_irq,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence read_of(a);
    bus.rd && (bus.addr == a);
  endsequence

  chk_status_flags:
  assert property (read_of(4'h1) |=> read_data[7] == $past(t1_irq) && read_data[5] == $past(t0_irq)
    && read_data[3] == $past(ext_irq1_req) && read_data[1] == $past(ext_irq0_req))
    else $error("status read disagrees with flag outputs");
  chk_t2_irq_flags:
  assert property (read_of(4'h6) |=> $past(t2_irq) == (read_data[7] | read_data[6]))
    else $error("timer 2 request does not match its flags");
  chk_t0_vector_clear:
  assert property (ack.t0 |=> !t0_irq) else $error("timer 0 flag kept after vectoring");
  chk_t1_vector_clear:
  assert property (ack.t1 |=> !t1_irq) else $error("timer 1 flag kept after vectoring");
  chk_t0_flag_hold:
  assert property ($fell(t0_irq) |-> $past(ack.t0 | bus.wr)) else $error("timer 0 flag dropped by itself");
  chk_t1_flag_hold:
  assert property ($fell(t1_irq) |-> $past(ack.t1 | bus.wr)) else $error("timer 1 flag dropped by itself");
  chk_t2_flag_hold:
  assert property ($fell(t2_irq) |-> $past(bus.wr, 2) || $past(bus.wr)) else $error("timer 2 flag dropped alone");
  chk_irq0_cause:
  assert property ($rose(ext_irq0_req) |-> !$past(pins.irq0) || !$past(pins.irq0, 2) || !$past(pins.irq0, 3)
    || !$past(pins.irq0, 4) || !$past(pins.irq0, 5)) else $error("irq0 request without a low pin");
  chk_irq1_cause:
  assert property ($rose(ext_irq1_req) |-> !$past(pins.irq1) || !$past(pins.irq1, 2) || !$past(pins.irq1, 3)
    || !$past(pins.irq1, 4) || !$past(pins.irq1, 5)) else $error("irq1 request without a low pin");
  chk_rx_tick_pulse:
  assert property (rx_baud_tick |=> !rx_baud_tick) else $error("receive bit clock wider than a cycle");
  chk_tx_tick_pulse:
  assert property (tx_baud_tick |=> !tx_baud_tick) else $error("transmit bit clock wider than a cycle");
endmodule

bind timer_unit timer_unit_chk chk_u (.clock(clock), .rst_n(rst_n), .bus(bus), .pins(pins), .ack(ack),
  .read_data(read_data), .t0_irq(t0_irq), .t1_irq(t1_irq), .ext_irq0_req(ext_irq0_req),
  .ext_irq1_req(ext_irq1_req), .t2_irq(t2_irq), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));

// [verification/cpu_side_model.sv]
module cpu_side_model
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire logic t0_irq,
  input wire logic t1_irq,
  input wire logic ext_irq0_req,
  input wire logic ext_irq1_req,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  output irq_ack_t ack,
  output logic [15:0] rx_count,
  output logic [15:0] tx_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // One vector at a time; waiting a cycle after each lets the cleared flag settle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack <= '0;
      rx_count <= 16'h0000;
      tx_count <= 16'h0000;
    end else begin
      ack <= '0;
      if (ack_en && ack == '0) begin
        if (ext_irq0_req) ack.x0 <= 1'b1;
        else if (t0_irq) ack.t0 <= 1'b1;
        else if (ext_irq1_req) ack.x1 <= 1'b1;
        else if (t1_irq) ack.t1 <= 1'b1;
      end
      if (rx_baud_tick) rx_count <= rx_count + 16'h0001;
      if (tx_baud_tick) tx_count <= tx_count + 16'h0001;
    end
  end
endmodule

// [verification/timer_unit_tb.sv]
module timer_unit_tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] exp_ctrl; logic [7:0] count_hi;
    logic [3:0] addr; logic [7:0] exp_byte;} trig_case_t;
  typedef struct packed {logic [7:0] mode; logic [7:0] ctrl; logic rx; logic tx;} baud_case_t;
  logic clock, rst_n, ack_en;
  reg_bus_t bus;
  ext_pins_t pins;
  irq_ack_t ack;
  logic [7:0] read_data, cap_lo;
  logic t0_irq, t1_irq, ext_irq0_req, ext_irq1_req, t2_irq, rx_baud_tick, tx_baud_tick;
  logic [1:0] ext_req;
  logic [15:0] rx_count, tx_count, rx0, tx0;
  logic [7:0] shadow [16];
  int err_count = 0;
  int n_tests = 0;
  trig_case_t trig_cases [3] = '{'{8'h0D, 8'h4D, 8'h40, 4'hA, 8'h40}, '{8'h05, 8'h05, 8'h20, 4'h8, 8'h20},
    '{8'h0C, 8'h4C, 8'h10, 4'h8, 8'h40}};
  baud_case_t baud_cases [3] = '{'{8'h33, 8'h24, 1'b1, 1'b0}, '{8'h33, 8'h14, 1'b0, 1'b1},
    '{8'h23, 8'h00, 1'b1, 1'b1}};

  assign ext_req = {ext_irq1_req, ext_irq0_req};
  timer_unit dut_u (.clock(clock), .rst_n(rst_n), .bus(bus), .pins(pins), .ack(ack), .read_data(read_data),
    .t0_irq(t0_irq), .t1_irq(t1_irq), .ext_irq0_req(ext_irq0_req), .ext_irq1_req(ext_irq1_req),
    .t2_irq(t2_irq), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));
  cpu_side_model cpu_u (.clock(clock), .rst_n(rst_n), .ack_en(ack_en), .t0_irq(t0_irq), .t1_irq(t1_irq),
    .ext_irq0_req(ext_irq0_req), .ext_irq1_req(ext_irq1_req), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .ack(ack), .rx_count(rx_count), .tx_count(tx_count));
  always #25 clock = ~clock;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 cmp(read_data, exp, what);
  endtask
  // Pins are held well over a machine cycle so the once-a-cycle sampler cannot miss a level
  task automatic hold(input int b, input logic v);
    @(posedge clock);
    pins[b] <= v;
    repeat (30) @(posedge clock);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    pins = '1;
    ack_en = 1'b0;
    void'($urandom(32'h82C4D584));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, "reset value");
    for (int a = 2; a <= 10; a++) begin
      if (a != 6) begin
        shadow[a] = 8'($urandom);
        wr(4'(a), shadow[a]);
        rd(4'(a), shadow[a], "byte register");
      end
    end
    wr(4'hF, 8'($urandom));
    rd(4'hF, 8'h00, "unmapped place");
    $display("test registers done");
    cap_lo = 8'($urandom) & 8'h7F;
    wr(4'h9, cap_lo);
    wr(4'h7, 8'hFE);
    wr(4'h8, 8'hFF);
    wr(4'h6, 8'h04);
    repeat (40) @(posedge clock);
    rd(4'h6, 8'h84, "timer 2 overflow flag");
    rd(4'h8, shadow[10], "timer 2 reloaded high byte");
    wr(4'h6, 8'h00);
    repeat (3) @(posedge clock);
    #1 cmp({7'h00, t2_irq}, 8'h00, "timer 2 request after clear");
    $display("test timer 2 reload done");
    wr(4'h0, 8'h33);
    wr(4'h2, 8'hFE);
    wr(4'h3, 8'hFE);
    wr(4'h1, 8'h50);
    repeat (40) @(posedge clock);
    rd(4'h1, 8'hF0, "split overflow flags");
    rd(4'h4, shadow[4], "timer 1 held low");
    rd(4'h5, shadow[5], "timer 1 held high");
    ack_en <= 1'b1;
    repeat (8) @(posedge clock);
    rd(4'h1, 8'h50, "flags after vectoring");
    ack_en <= 1'b0;
    $display("test split mode done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h1, 8'h00);
      hold(4 + i, 1'b0);
      cmp({7'h00, ext_req[i]}, 8'h01, "level request low");
      hold(4 + i, 1'b1);
      cmp({7'h00, ext_req[i]}, 8'h00, "level request high");
      wr(4'h1, 8'h05);
      hold(4 + i, 1'b0);
      hold(4 + i, 1'b1);
      cmp({7'h00, ext_req[i]}, 8'h01, "edge request latched");
      ack_en <= 1'b1;
      repeat (8) @(posedge clock);
      #1 cmp({7'h00, ext_req[i]}, 8'h00, "edge request vectored");
      ack_en <= 1'b0;
    end
    $display("test external requests done");
    wr(4'h6, 8'h00);
    wr(4'h7, 8'hF0);
    wr(4'h8, 8'hFF);
    wr(4'h9, 8'hF0);
    wr(4'hA, 8'hFF);
    wr(4'h5, 8'hFF);
    // Low byte at the reload value too, so timer 1 overflows every machine cycle
    wr(4'h4, 8'hFF);
    foreach (baud_cases[k]) begin
      wr(4'h0, baud_cases[k].mode);
      wr(4'h6, baud_cases[k].ctrl);
      // A tick launched under the old selection may still be in flight
      repeat (4) @(posedge clock);
      rx0 = rx_count;
      tx0 = tx_count;
      repeat (200) @(posedge clock);
      #1 cmp({7'h00, rx_count != rx0}, {7'h00, baud_cases[k].rx}, "receive bit clock");
      cmp({7'h00, tx_count != tx0}, {7'h00, baud_cases[k].tx}, "transmit bit clock");
      rd(4'h6, baud_cases[k].ctrl, "no overflow flag in baud mode");
    end
    $display("test baud clocks done");
    foreach (trig_cases[k]) begin
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h00);
      wr(4'h8, trig_cases[k].count_hi);
      wr(4'h6, trig_cases[k].ctrl);
      hold(3, 1'b0);
      cmp({7'h00, t2_irq}, {7'h00, trig_cases[k].exp_ctrl[6]}, "trigger request");
      hold(3, 1'b1);
      rd(4'h6, trig_cases[k].exp_ctrl, "trigger flag");
      rd(trig_cases[k].addr, trig_cases[k].exp_byte, "trigger capture or reload");
    end
    $display("test trigger done");
    wr(4'h6, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h1, 8'h10);
    wr(4'h6, 8'h06);
    repeat (3) begin
      hold(0, 1'b0);
      hold(2, 1'b0);
      hold(0, 1'b1);
      hold(2, 1'b1);
    end
    rd(4'h2, 8'h03, "timer 0 counted pin falls");
    rd(4'h7, 8'h03, "timer 2 counted pin falls");
    rd(4'h6, 8'h06, "timer 2 counter flags");
    $display("test counters done");
    complete_run();
  end
endmodule
